// *** verilog/cpu_regset.sv ***
// architectural register set with operand widening and alignment checks
//
// Notes on behaviour
// - sixteen general, three control, four system registers
// - register zero is the index register
// - register fifteen is the exception stack pointer
// - global base forms peripheral base addresses
// - vector base locates exception and interrupt vectors
// - multiply results held as high/low pair
// - link holds return address, pointer holds fetch
// - reset loads pointer and stack from vectors
// - reset sets mask field ones, reserved zero
// - reset clears vector base, others need not
// - register operands are always full longwords
// - byte and word loads are sign extended
// - byte accesses allowed at any address
// - misaligned word or longword raises address error
// - stack accessed only by aligned longwords
// - arithmetic byte immediates are sign extended
// - logic byte immediates are zero extended
// - wide immediates come from memory tables
`timescale 1ns/1ps
`include "cpu_regset_regs.svh"

module cpu_regset (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // software register port
    input wire logic [`ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // interrupt
    output logic IRQ,
    // reset vector fetch
    output logic VEC_REQ,
    output logic [31:0] VEC_ADDR,
    input wire logic [31:0] VEC_DATA,
    input wire logic VEC_ACK,
    output logic CORE_READY,
    // general register reads
    input wire logic [3:0] RD_SEL_A,
    input wire logic [3:0] RD_SEL_B,
    output logic [31:0] RD_DATA_A,
    output logic [31:0] RD_DATA_B,
    output logic [31:0] INDEX_DATA,
    output logic [31:0] GBR_INDEX_ADDR,
    // general register write back
    input wire logic WB_EN,
    input wire logic [3:0] WB_SEL,
    input wire cpu_regset_pkg::wb_src_type WB_SRC,
    input wire cpu_regset_pkg::size_type WB_SIZE,
    input wire cpu_regset_pkg::imm_kind_type WB_IMM_KIND,
    input wire logic [31:0] WB_DATA,
    input wire logic [7:0] WB_IMM,
    // memory access check
    input wire logic ACC_EN,
    input wire logic [31:0] ACC_ADDR,
    input wire cpu_regset_pkg::size_type ACC_SIZE,
    input wire logic ACC_STACK,
    output logic ADDR_ERR,
    output logic [31:0] ERR_VECTOR,
    // exception stack
    input wire logic STACK_PUSH,
    input wire logic STACK_POP,
    output logic [31:0] STACK_ADDR,
    // multiply accumulate pair
    input wire logic MAC_WR,
    input wire logic [31:0] MAC_HIGH_IN,
    input wire logic [31:0] MAC_LOW_IN,
    output logic [31:0] MAC_HIGH,
    output logic [31:0] MAC_LOW,
    // link and instruction pointer
    input wire logic LINK_WR,
    input wire logic [31:0] LINK_IN,
    input wire logic PC_WR,
    input wire logic [31:0] PC_IN,
    output logic [31:0] LINK_OUT,
    output logic [31:0] PC_OUT,
    // control register views
    output logic [31:0] STATUS_OUT,
    output logic [31:0] GBR_OUT,
    output logic [31:0] VBR_OUT
);
    import cpu_regset_pkg::*;

    // widen a memory operand to a longword, sign extended
    function automatic logic [31:0] widen_load(input logic [31:0] d,
                                               input size_type s);
        unique case (s)
            size_byte: widen_load = {{24{d[7]}}, d[7:0]};
            size_word: widen_load = {{16{d[15]}}, d[15:0]};
            size_long: widen_load = d;
            default: widen_load = d;
        endcase
    endfunction : widen_load

    // widen a byte immediate; wider ones arrive as table loads
    function automatic logic [31:0] widen_imm(input logic [7:0] i,
                                              input imm_kind_type k);
        if (k == imm_arith) begin
            widen_imm = {{24{i[7]}}, i};
        end else begin
            widen_imm = {24'h000000, i};
        end
    endfunction : widen_imm

    // true when an access breaks the alignment of its size
    function automatic logic misaligned(input logic [31:0] a,
                                        input size_type s,
                                        input logic stk);
        logic bad;
        bad = 1'b0;
        unique case (s)
            size_byte: bad = 1'b0;
            size_word: bad = a[0];
            size_long: bad = a[1] | a[0];
            default: bad = 1'b1;
        endcase
        // stack holds saved pointer and status words only
        misaligned = bad | (stk & (s != size_long));
    endfunction : misaligned

    // register state
    logic [31:0] gpr_reg [0:15]; // general registers
    logic [31:0] gpr_next [0:15];
    logic [31:0] status_reg, status_next; // status word
    logic [31:0] gbase_reg, gbase_next; // global base
    logic [31:0] vbase_reg, vbase_next; // vector base
    logic [31:0] multiply_accum_high_reg, multiply_accum_high_next; // multiply high
    logic [31:0] multiply_accum_low_reg, multiply_accum_low_next; // multiply low
    logic [31:0] link_reg, link_next; // subroutine link
    logic [31:0] iptr_reg, iptr_next; // instruction pointer
    logic [31:0] istat_reg, istat_next; // sticky events
    logic [31:0] imask_reg, imask_next; // event mask
    // registered outputs
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] rda_reg, rda_next;
    logic [31:0] rdb_reg, rdb_next;
    logic [31:0] gidx_reg, gidx_next;
    logic [31:0] stk_reg, stk_next;
    logic err_reg, err_next;
    logic [31:0] errvec_reg, errvec_next;
    // boot sequencer
    boot_type state_reg, state_next;
    logic [31:0] vaddr_reg, vaddr_next;
    logic boot_done; // last vector taken this cycle
    logic err_now; // misaligned access this cycle

    assign err_now = ACC_EN & misaligned(ACC_ADDR, ACC_SIZE, ACC_STACK);
    assign boot_done = (state_reg == st_load_sp) & VEC_ACK;

    // boot sequencer next state: pointer, then stack, then run
    always_comb begin
        state_next = state_reg;
        vaddr_next = vaddr_reg;
        unique case (state_reg)
            st_load_pc: begin
                if (VEC_ACK) begin
                    state_next = st_load_sp;
                    vaddr_next = vbase_reg + `VEC_SP_OFS;
                end
            end
            st_load_sp: begin
                if (VEC_ACK) begin
                    state_next = st_run;
                end
            end
            st_run: begin
                state_next = st_run;
            end
        endcase
    end

    // boot sequencer registers; vector base is zero at reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= st_load_pc;
            vaddr_reg <= `VBASE_RESET + `VEC_PC_OFS;
        end else begin
            state_reg <= state_next;
            vaddr_reg <= vaddr_next;
        end
    end

    // general registers: write back, stack moves, vector load
    always_comb begin
        logic [31:0] wv;
        wv = WB_DATA;
        for (int i = 0; i < 16; i++) begin
            gpr_next[i] = gpr_reg[i];
        end
        unique case (WB_SRC)
            wb_mem: wv = widen_load(WB_DATA, WB_SIZE);
            wb_imm: wv = widen_imm(WB_IMM, WB_IMM_KIND);
            default: wv = WB_DATA;
        endcase
        if (WB_EN) begin
            gpr_next[WB_SEL] = wv;
        end
        // stack moves win over a write back to register fifteen
        if (state_reg != st_run) begin
            if (boot_done) begin
                gpr_next[`SP_INDEX] = VEC_DATA;
            end
        end else if (STACK_PUSH & ~STACK_POP) begin
            gpr_next[`SP_INDEX] = gpr_reg[`SP_INDEX] - `STACK_STEP;
        end else if (STACK_POP & ~STACK_PUSH) begin
            gpr_next[`SP_INDEX] = gpr_reg[`SP_INDEX] + `STACK_STEP;
        end
        // read ports and global index address one cycle late; stack address in step with register fifteen
        rda_next = gpr_reg[RD_SEL_A];
        rdb_next = gpr_reg[RD_SEL_B];
        gidx_next = gbase_reg + gpr_reg[`IDX_INDEX];
        stk_next = gpr_next[`SP_INDEX];
    end

    // general registers hold data only, so they carry no reset
    always_ff @(posedge REF_CLK) begin
        for (int i = 0; i < 16; i++) begin
            gpr_reg[i] <= gpr_next[i];
        end
        if (RST) begin
            rda_reg <= 32'h00000000;
            rdb_reg <= 32'h00000000;
            gidx_reg <= 32'h00000000;
            stk_reg <= 32'h00000000;
        end else begin
            rda_reg <= rda_next;
            rdb_reg <= rdb_next;
            gidx_reg <= gidx_next;
            stk_reg <= stk_next;
        end
    end

    // control and system registers, events and the software port
    always_comb begin
        status_next = status_reg;
        gbase_next = gbase_reg;
        vbase_next = vbase_reg;
        multiply_accum_high_next = multiply_accum_high_reg;
        multiply_accum_low_next = multiply_accum_low_reg;
        link_next = link_reg;
        iptr_next = iptr_reg;
        istat_next = istat_reg;
        imask_next = imask_reg;
        rdata_next = 32'h00000000;
        err_next = err_now;
        errvec_next = errvec_reg;
        if (err_now) begin
            errvec_next = vbase_reg + `VEC_ADDR_ERR_OFS;
        end
        if (REG_WR) begin
            unique case (REG_ADDR)
                `OFS_STATUS: status_next = REG_WDATA & `SR_WRITABLE;
                `OFS_GBASE: gbase_next = REG_WDATA;
                `OFS_VBASE: vbase_next = REG_WDATA;
                `OFS_MULTIPLY_ACCUM_HIGH: multiply_accum_high_next = REG_WDATA;
                `OFS_MULTIPLY_ACCUM_LOW: multiply_accum_low_next = REG_WDATA;
                `OFS_LINK: link_next = REG_WDATA;
                `OFS_IPTR: iptr_next = REG_WDATA;
                `OFS_ISTAT: istat_next = istat_reg & ~REG_WDATA;
                `OFS_IMASK: imask_next = REG_WDATA & `IRQ_USED;
                default: ; // unmapped writes are dropped
            endcase
        end
        // datapath updates win over a software write in the same cycle
        if (MAC_WR) begin
            multiply_accum_high_next = MAC_HIGH_IN;
            multiply_accum_low_next = MAC_LOW_IN;
        end
        if (LINK_WR) begin
            link_next = LINK_IN;
        end
        if (state_reg == st_load_pc) begin
            if (VEC_ACK) begin
                iptr_next = VEC_DATA;
            end
        end else if (PC_WR) begin
            iptr_next = PC_IN;
        end
        // events set after the clear, so a colliding event survives
        if (err_now) begin
            istat_next[`IRQ_ADDR_ERR] = 1'b1;
        end
        if (boot_done) begin
            istat_next[`IRQ_BOOT_DONE] = 1'b1;
        end
        if (REG_RD) begin
            if (REG_ADDR >= `OFS_GPR_LO && REG_ADDR <= `OFS_GPR_HI
                && REG_ADDR[1:0] == 2'b00) begin
                rdata_next = gpr_reg[REG_ADDR[5:2]];
            end else begin
                unique case (REG_ADDR)
                    `OFS_STATUS: rdata_next = status_reg;
                    `OFS_GBASE: rdata_next = gbase_reg;
                    `OFS_VBASE: rdata_next = vbase_reg;
                    `OFS_MULTIPLY_ACCUM_HIGH: rdata_next = multiply_accum_high_reg;
                    `OFS_MULTIPLY_ACCUM_LOW: rdata_next = multiply_accum_low_reg;
                    `OFS_LINK: rdata_next = link_reg;
                    `OFS_IPTR: rdata_next = iptr_reg;
                    `OFS_ISTAT: rdata_next = istat_reg;
                    `OFS_IMASK: rdata_next = imask_reg;
                    default: rdata_next = 32'h00000000;
                endcase
            end
        end
    end

    // register the control group; undefined status bits start at zero
    always_ff @(posedge REF_CLK) begin
        gbase_reg <= gbase_next;
        multiply_accum_high_reg <= multiply_accum_high_next;
        multiply_accum_low_reg <= multiply_accum_low_next;
        link_reg <= link_next;
        iptr_reg <= iptr_next;
        if (RST) begin
            status_reg <= {24'h000000, `SR_MASK_RESET, 4'h0};
            vbase_reg <= `VBASE_RESET;
            istat_reg <= 32'h00000000;
            imask_reg <= 32'h00000000;
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
            errvec_reg <= 32'h00000000;
        end else begin
            status_reg <= status_next;
            vbase_reg <= vbase_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            errvec_reg <= errvec_next;
        end
    end

    // outputs
    assign REG_RDATA = rdata_reg;
    assign IRQ = |(istat_reg & imask_reg);
    assign VEC_REQ = (state_reg != st_run);
    assign VEC_ADDR = vaddr_reg;
    assign CORE_READY = (state_reg == st_run);
    assign RD_DATA_A = rda_reg;
    assign RD_DATA_B = rdb_reg;
    assign INDEX_DATA = gpr_reg[`IDX_INDEX];
    assign GBR_INDEX_ADDR = gidx_reg;
    assign ADDR_ERR = err_reg;
    assign ERR_VECTOR = errvec_reg;
    assign STACK_ADDR = stk_reg;
    assign MAC_HIGH = multiply_accum_high_reg;
    assign MAC_LOW = multiply_accum_low_reg;
    assign LINK_OUT = link_reg;
    assign PC_OUT = iptr_reg;
    assign STATUS_OUT = status_reg;
    assign GBR_OUT = gbase_reg;
    assign VBR_OUT = vbase_reg;

    // checks
    default clocking chk_clk @(posedge REF_CLK); endclocking
    default disable iff (1'b0);

    mask_reset_a: assert property (RST |=>
        status_reg[`SR_MASK_MSB:`SR_MASK_LSB] == `SR_MASK_RESET)
        else $error("mask field not all ones after reset");
    vbase_reset_a: assert property (RST |=> vbase_reg == 32'h0)
        else $error("vector base not cleared by reset");
    boot_pc_a: assert property (disable iff (RST)
        state_reg == st_load_pc && VEC_ACK |=>
        iptr_reg == $past(VEC_DATA) && state_reg == st_load_sp)
        else $error("pointer not loaded from vector");
    word_align_a: assert property (disable iff (RST)
        ACC_EN && ACC_SIZE == size_word && ACC_ADDR[0] |=>
        ADDR_ERR ##1 istat_reg[`IRQ_ADDR_ERR])
        else $error("odd word access not flagged");
    byte_free_a: assert property (disable iff (RST)
        ACC_EN && ACC_SIZE == size_byte && !ACC_STACK |=> !ADDR_ERR)
        else $error("byte access flagged");
    stack_long_a: assert property (disable iff (RST)
        ACC_EN && ACC_STACK && ACC_SIZE != size_long |=> ADDR_ERR)
        else $error("narrow stack access not flagged");
    load_sign_a: assert property (disable iff (RST)
        WB_EN && WB_SRC == wb_mem && WB_SIZE == size_byte &&
        WB_SEL != `SP_INDEX |=> gpr_reg[$past(WB_SEL)] ==
        {{24{$past(WB_DATA[7])}}, $past(WB_DATA[7:0])})
        else $error("byte load not sign extended");
    logic_imm_a: assert property (disable iff (RST)
        WB_EN && WB_SRC == wb_imm && WB_IMM_KIND == imm_logic &&
        WB_SEL != `SP_INDEX |=> gpr_reg[$past(WB_SEL)][31:8] == 24'h0)
        else $error("logic immediate upper bits not clear");
    push_step_a: assert property (disable iff (RST)
        CORE_READY && STACK_PUSH && !STACK_POP |=>
        gpr_reg[`SP_INDEX] == $past(gpr_reg[`SP_INDEX]) - 32'h4
        ##1 STACK_ADDR == $past(gpr_reg[`SP_INDEX]))
        else $error("push did not step stack by four");
    mac_pair_a: assert property (disable iff (RST) MAC_WR |=>
        multiply_accum_high_reg == $past(MAC_HIGH_IN) && multiply_accum_low_reg == $past(MAC_LOW_IN))
        else $error("multiply pair not stored together");
    err_vector_a: assert property (disable iff (RST)
        ADDR_ERR |-> ERR_VECTOR == $past(vbase_reg) + `VEC_ADDR_ERR_OFS)
        else $error("error vector not relative to vector base");
endmodule : cpu_regset

// *** verilog/cpu_regset_regs.svh ***
// offsets, field positions, reset values and vector offsets of the register set
`ifndef CPU_REGSET_REGS_SVH
`define CPU_REGSET_REGS_SVH
`define ADDR_W 8
`define OFS_STATUS 8'h00
`define OFS_GBASE 8'h04
`define OFS_VBASE 8'h08
`define OFS_MULTIPLY_ACCUM_HIGH 8'h0C
`define OFS_MULTIPLY_ACCUM_LOW 8'h10
`define OFS_LINK 8'h14
`define OFS_IPTR 8'h18
`define OFS_ISTAT 8'h1C
`define OFS_IMASK 8'h20
`define OFS_GPR_LO 8'h40
`define OFS_GPR_HI 8'h7C
`define SR_MASK_LSB 4
`define SR_MASK_MSB 7
`define SR_MASK_RESET 4'hF
`define SR_WRITABLE 32'h000003F3
`define VBASE_RESET 32'h00000000
`define VEC_PC_OFS 32'h00000000
`define VEC_SP_OFS 32'h00000004
`define VEC_ADDR_ERR_OFS 32'h00000024
`define STACK_STEP 32'h00000004
`define SP_INDEX 4'hF
`define IDX_INDEX 4'h0
`define IRQ_ADDR_ERR 0
`define IRQ_BOOT_DONE 1
`define IRQ_USED 32'h00000003
`endif

// *** verilog/cpu_regset_pkg.sv ***
// types shared by the register set and its users
package cpu_regset_pkg;
    // width of a memory operand or access
    typedef enum logic [1:0] {size_byte, size_word, size_long} size_type;
    // how a byte immediate is widened
    typedef enum logic {imm_arith, imm_logic} imm_kind_type;
    // source of a general register write
    typedef enum logic [1:0] {wb_alu, wb_mem, wb_imm} wb_src_type;
    // reset vector load sequence
    typedef enum logic [1:0] {st_load_pc, st_load_sp, st_run} boot_type;
endpackage : cpu_regset_pkg

// *** dv/tb_cpu_regset.sv ***
// self-checking bench for the architectural register set
`timescale 1ns/1ps
`include "cpu_regset_regs.svh"

module tb_cpu_regset;
    import cpu_regset_pkg::*;
    // clock, reset and register port
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, irq;
    // vector fetch
    logic vec_req, vec_ack, core_ready;
    logic [31:0] vec_addr, vec_data;
    // general register paths
    logic [3:0] sel_a, sel_b, wb_sel;
    logic [31:0] rd_a, rd_b, idx, gidx, wb_data;
    logic wb_en;
    wb_src_type wb_src;
    size_type wb_size, acc_size;
    imm_kind_type wb_kind;
    logic [7:0] wb_byte; // byte immediate, apart from the wb_imm source code
    // access check and stack
    logic acc_en, acc_stack, addr_err, push, pop;
    logic [31:0] acc_addr, err_vec, stk_addr;
    // system register writes and views
    logic mac_wr, link_wr, pc_wr;
    logic [31:0] mac_hi_in, mac_lo_in, mac_hi, mac_lo, link_in, pc_in;
    logic [31:0] link_out, pc_out, status, global_base, vector_base;
    // result counters
    int mismatches = 0;
    int checked = 0;

    // 20 MHz core clock
    always #25 ref_clk = ~ref_clk;

    cpu_regset u_cpu_regset (.REF_CLK(ref_clk), .RST(rst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq),
        .VEC_REQ(vec_req), .VEC_ADDR(vec_addr), .VEC_DATA(vec_data),
        .VEC_ACK(vec_ack), .CORE_READY(core_ready),
        .RD_SEL_A(sel_a), .RD_SEL_B(sel_b), .RD_DATA_A(rd_a),
        .RD_DATA_B(rd_b), .INDEX_DATA(idx), .GBR_INDEX_ADDR(gidx),
        .WB_EN(wb_en), .WB_SEL(wb_sel), .WB_SRC(wb_src),
        .WB_SIZE(wb_size), .WB_IMM_KIND(wb_kind), .WB_DATA(wb_data),
        .WB_IMM(wb_byte), .ACC_EN(acc_en), .ACC_ADDR(acc_addr),
        .ACC_SIZE(acc_size), .ACC_STACK(acc_stack), .ADDR_ERR(addr_err),
        .ERR_VECTOR(err_vec), .STACK_PUSH(push), .STACK_POP(pop),
        .STACK_ADDR(stk_addr), .MAC_WR(mac_wr), .MAC_HIGH_IN(mac_hi_in),
        .MAC_LOW_IN(mac_lo_in), .MAC_HIGH(mac_hi), .MAC_LOW(mac_lo),
        .LINK_WR(link_wr), .LINK_IN(link_in), .PC_WR(pc_wr),
        .PC_IN(pc_in), .LINK_OUT(link_out), .PC_OUT(pc_out),
        .STATUS_OUT(status), .GBR_OUT(global_base), .VBR_OUT(vector_base));

    // verdict and end of run, shared with the watchdog
    task summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // word compare
    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp32

    // flag compare
    task cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp1

    // one-cycle software write
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // one-cycle read; data stands only in the following cycle
    task reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 cmp32(reg_rdata, e);
    endtask : reg_read

    // write back one register, then read it through the window
    task wb(input logic [3:0] s, input wb_src_type src, input size_type z,
            input imm_kind_type k, input logic [31:0] d,
            input logic [7:0] i, input logic [31:0] e);
        @(posedge ref_clk);
        wb_en <= 1'b1;
        wb_sel <= s;
        wb_src <= src;
        wb_size <= z;
        wb_kind <= k;
        wb_data <= d;
        wb_byte <= i;
        @(posedge ref_clk);
        wb_en <= 1'b0;
        reg_read(`OFS_GPR_LO + {2'b00, s, 2'b00}, e);
    endtask : wb

    // alignment check; vector base is 0x4000 while this runs
    task acc(input logic [31:0] a, input size_type z, input logic stk,
             input logic e);
        @(posedge ref_clk);
        acc_en <= 1'b1;
        acc_addr <= a;
        acc_size <= z;
        acc_stack <= stk;
        @(posedge ref_clk);
        acc_en <= 1'b0;
        #1 cmp1(addr_err, e);
        if (e) begin
            cmp32(err_vec, 32'h00004000 + `VEC_ADDR_ERR_OFS);
        end
    endtask : acc

    // a hang is cut short well past the expected hundred or so cycles
    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, vec_data, vec_ack} = '0;
        {sel_a, sel_b, wb_sel, wb_en, wb_data, wb_byte} = '0;
        {acc_en, acc_addr, acc_stack, push, pop} = '0;
        {mac_wr, link_wr, pc_wr, mac_hi_in, mac_lo_in} = '0;
        {link_in, pc_in} = '0;
        wb_src = wb_alu;
        wb_size = size_long;
        acc_size = size_long;
        wb_kind = imm_arith;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1 cmp1(vec_req, 1'b1);
        cmp32(vec_addr, `VEC_PC_OFS);
        reg_read(`OFS_STATUS, 32'h000000F0);
        reg_read(`OFS_VBASE, `VBASE_RESET);
        // pointer entry then stack entry, acks back to back
        @(posedge ref_clk);
        vec_ack <= 1'b1;
        vec_data <= 32'h00001000;
        @(posedge ref_clk);
        vec_data <= 32'h00002000;
        #1 cmp32(pc_out, 32'h00001000);
        cmp32(vec_addr, `VEC_SP_OFS);
        @(posedge ref_clk);
        vec_ack <= 1'b0;
        #1 cmp1(core_ready, 1'b1);
        cmp1(vec_req, 1'b0);
        reg_read(`OFS_GPR_HI, 32'h00002000);
        reg_read(`OFS_ISTAT, 32'h00000002);
        // interrupt masked, unmasked, then cleared
        cmp1(irq, 1'b0);
        reg_write(`OFS_IMASK, 32'h00000002);
        @(posedge ref_clk);
        #1 cmp1(irq, 1'b1);
        reg_write(`OFS_ISTAT, 32'h00000002);
        @(posedge ref_clk);
        #1 cmp1(irq, 1'b0);
        // control registers; reserved status bits stay zero
        reg_write(`OFS_STATUS, 32'hFFFFFFFF);
        reg_read(`OFS_STATUS, `SR_WRITABLE);
        cmp32(status, `SR_WRITABLE);
        reg_write(`OFS_VBASE, 32'h00004000);
        reg_write(`OFS_GBASE, 32'h00008000);
        reg_write(`OFS_GPR_HI, 32'hDEADBEEF);
        reg_read(`OFS_GPR_HI, 32'h00002000);
        reg_read(8'h30, 32'h00000000);
        #1 cmp32(vector_base, 32'h00004000);
        cmp32(global_base, 32'h00008000);
        // immediate and memory widening
        wb(4'h0, wb_imm, size_byte, imm_logic, 32'h0, 8'h80,
           32'h80);
        wb(4'h1, wb_imm, size_byte, imm_arith, 32'h0, 8'h80,
           32'hFFFFFF80);
        wb(4'h2, wb_mem, size_byte, imm_arith, 32'hFE, 8'h00,
           32'hFFFFFFFE);
        wb(4'h3, wb_mem, size_word, imm_arith, 32'h8001, 8'h00,
           32'hFFFF8001);
        wb(4'h4, wb_mem, size_long, imm_logic, 32'h87654321, 8'h00,
           32'h87654321);
        wb(4'h5, wb_alu, size_byte, imm_arith, 32'h80, 8'h00,
           32'h80);
        cmp32(idx, 32'h00000080);
        cmp32(gidx, 32'h00008080);
        @(posedge ref_clk);
        sel_a <= 4'h1;
        sel_b <= 4'h3;
        @(posedge ref_clk);
        #1 cmp32(rd_a, 32'hFFFFFF80);
        cmp32(rd_b, 32'hFFFF8001);
        // alignment table, error vector relative to vector base
        acc(32'h3, size_byte, 1'b0, 1'b0);
        acc(32'h1, size_word, 1'b0, 1'b1);
        acc(32'h2, size_word, 1'b0, 1'b0);
        acc(32'h2, size_long, 1'b0, 1'b1);
        acc(32'h4, size_long, 1'b0, 1'b0);
        acc(32'h4, size_word, 1'b1, 1'b1);
        acc(32'h8, size_long, 1'b1, 1'b0);
        reg_read(`OFS_ISTAT, 32'h00000001);
        cmp1(irq, 1'b0);
        reg_write(`OFS_IMASK, 32'h00000003);
        @(posedge ref_clk);
        #1 cmp1(irq, 1'b1);
        // exception stack moves by one longword
        @(posedge ref_clk);
        push <= 1'b1;
        @(posedge ref_clk);
        push <= 1'b0;
        @(posedge ref_clk);
        #1 cmp32(stk_addr, 32'h00001FFC);
        reg_read(`OFS_GPR_HI, 32'h00001FFC);
        @(posedge ref_clk);
        pop <= 1'b1;
        @(posedge ref_clk);
        pop <= 1'b0;
        @(posedge ref_clk);
        #1 cmp32(stk_addr, 32'h00002000);
        // multiply pair, link and pointer written together
        @(posedge ref_clk);
        {mac_wr, link_wr, pc_wr} <= 3'h7;
        mac_hi_in <= 32'h11112222;
        mac_lo_in <= 32'h33334444;
        link_in <= 32'h00000C00;
        pc_in <= 32'h00000E00;
        @(posedge ref_clk);
        {mac_wr, link_wr, pc_wr} <= 3'h0;
        @(posedge ref_clk);
        #1 cmp32(mac_hi, 32'h11112222);
        cmp32(mac_lo, 32'h33334444);
        cmp32(link_out, 32'h00000C00);
        cmp32(pc_out, 32'h00000E00);
        reg_read(`OFS_MULTIPLY_ACCUM_LOW, 32'h33334444);
        reg_read(`OFS_LINK, 32'h00000C00);
        summarize();
    end
endmodule : tb_cpu_regset
